// ===== rtl/sbarb_regs.svh
// register offsets, reset values, field positions and counts of the secondary bus arbiter
`ifndef SBARB_REGS_SVH
`define SBARB_REGS_SVH

`define SBARB_OFS_VENDOR_A     8'hd9
`define SBARB_OFS_VENDOR_B     8'hda
`define SBARB_OFS_PRIORITY     8'hdc
`define SBARB_OFS_IGNORE       8'hdd
`define SBARB_OFS_EXPIRY_STAT  8'hde

`define SBARB_RST_VENDOR_A     8'h00
`define SBARB_RST_VENDOR_B     8'h00
`define SBARB_RST_PRIORITY     8'h40
`define SBARB_RST_IGNORE       8'h00
`define SBARB_RST_EXPIRY_STAT  8'h00

// grant_priority_control fields
`define SBARB_PRI_PARK_BRIDGE  7
`define SBARB_PRI_BRIDGE_HIGH  6
`define SBARB_PRI_PORT0_HIGH   0

// request_ignore_control fields
`define SBARB_IGN_EXPIRY_EN    7
`define SBARB_IGN_AUTO_MASK    6
`define SBARB_IGN_PORT0        0

// status field
`define SBARB_STAT_PORT0       0

// idle clocks a granted master has to start its frame
`define SBARB_EXPIRY_CLKS      16

`endif

// ===== rtl/sbarb_pkg.sv
// types shared by the secondary bus arbiter modules
package sbarb_pkg;

    // arbitration phase, one-hot
    typedef enum logic [2:0] {
        SBARB_ARB  = 3'b001,
        SBARB_BUSY = 3'b010,
        SBARB_HOLD = 3'b100
    } sbarb_state_t;

    // one-hot master vector: bit 0 port 0, bit 1 the bridge
    typedef logic [1:0] sbarb_master_t;

endpackage

// ===== rtl/sbarb_expiry_if.sv
// link between the arbiter core and its grant expiry counter
`timescale 1ns/1ps
interface sbarb_expiry_if;
    logic run;
    logic expired;
    logic [4:0] count;

    modport ctl (output run, input expired, input count);
    modport cnt (input run, output expired, output count);
endinterface

// ===== rtl/sbarb_expiry.sv
// grant expiry counter: counts idle clocks while a granted master stays silent
`timescale 1ns/1ps
`include "sbarb_regs.svh"
module sbarb_expiry import sbarb_pkg::*; #(
    parameter int LIMIT = `SBARB_EXPIRY_CLKS
) (
    input wire logic clk,
    input wire logic rst,
    sbarb_expiry_if.cnt e
);
    // five count bits and a one-clock registered pulse bound the usable limit
    if (LIMIT < 2 || LIMIT > 31) begin : g_bad_limit
        $error("sbarb_expiry: LIMIT out of range");
    end

    logic [4:0] cnt;
    logic hit;
    logic [4:0] next_cnt;
    logic next_hit;

    // counter restarts whenever the wait is broken, so only a solid idle run expires
    always_comb begin
        next_hit = 1'b0;
        next_cnt = 5'h00;
        if (e.run) begin
            if (cnt == 5'(LIMIT - 1)) begin
                next_hit = 1'b1;
            end else begin
                next_cnt = cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= 5'h00;
            hit <= 1'b0;
        end else begin
            cnt <= next_cnt;
            hit <= next_hit;
        end
    end

    assign e.expired = hit;
    assign e.count = cnt;

    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);

    a_expiry_after_limit: assert property (e.expired |-> $past(cnt) == 5'(LIMIT - 1))
        else $error("expiry fired before the idle limit");
endmodule

// ===== rtl/sbarb_top.sv
// secondary bus arbiter: two-tier rotating grant, parking, grant expiry and config bytes
`timescale 1ns/1ps
`include "sbarb_regs.svh"
// Behaviour
// - two priority tiers, rotating fairly among requesters inside each tier
// - after reset only the bridge sits in the high tier
// - idle bus parks on bridge when park bit set, else on last owner
// - bridge tier bit: 1 high tier (default), 0 low tier
// - port 0 tier bit: 1 high tier, 0 low tier (default)
// - expiry enable gives a 16 clock limit; clear disables expiry detection
// - granted port 0 must start a frame within the limit, else non-responding; the bridge grant never expires
// - auto-mask bit masks the request of a master that expired
// - port 0 ignore bit makes the arbiter disregard request input 0
// - control bits return to their reset values on RST or on fundamental reset, from link or global reset
// - priority byte at DCh, reset 40h
// - ignore byte at DDh, reset 00h
// - vendor byte DAh is read-only and returns 00h
// - expiry sets port 0 flag in status byte DEh; reading clears it
module sbarb_top import sbarb_pkg::*; #(
    parameter int EXPIRY_CLKS = `SBARB_EXPIRY_CLKS
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic LINK_RESET_N,
    input wire logic GLOBAL_RESET_N,
    // secondary bus
    input wire logic REQ0_N,
    input wire logic FRAME_N,
    input wire logic IRDY_N,
    output logic GNT0_N,
    // bridge master side
    input wire logic BRIDGE_REQ,
    output logic BRIDGE_GNT,
    // configuration byte access
    input wire logic [7:0] CFG_ADDR,
    input wire logic CFG_WR,
    input wire logic CFG_RD,
    input wire logic [7:0] CFG_WDATA,
    output logic [7:0] CFG_RDATA
);
    if (EXPIRY_CLKS != `SBARB_EXPIRY_CLKS) begin : g_bad_expiry
        $error("sbarb_top: expiry limit is fixed by the register definition");
    end

    // ------------------------------------------------------------
    // fundamental reset from the reset pins
    // ------------------------------------------------------------
    logic [2:0] link_s;
    logic [2:0] glob_s;
    logic link_lvl;
    logic glob_lvl;
    logic next_link_lvl;
    logic next_glob_lvl;
    logic fundamental_reset_n;
    logic cfg_clear;

    always_comb begin
        next_link_lvl = (link_s[1] == link_s[2]) ? link_s[2] : link_lvl;
        next_glob_lvl = (glob_s[1] == glob_s[2]) ? glob_s[2] : glob_lvl;
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            link_s <= 3'h0;
            glob_s <= 3'h0;
            link_lvl <= 1'b0;
            glob_lvl <= 1'b0;
        end else begin
            link_s <= {link_s[1:0], LINK_RESET_N};
            glob_s <= {glob_s[1:0], GLOBAL_RESET_N};
            link_lvl <= next_link_lvl;
            glob_lvl <= next_glob_lvl;
        end
    end

    assign fundamental_reset_n = link_lvl & glob_lvl;
    assign cfg_clear = RST | ~fundamental_reset_n;

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    sbarb_expiry_if ex ();
    sbarb_expiry #(.LIMIT(EXPIRY_CLKS)) u_expiry (.clk(CLOCK), .rst(cfg_clear), .e(ex.cnt));

    logic [7:0] vendor_a;
    logic [7:0] pri_ctl;
    logic [7:0] ign_ctl;
    logic port0_expiry_flag;
    sbarb_state_t state;
    sbarb_master_t grant;
    sbarb_master_t last;
    sbarb_state_t next_state;
    sbarb_master_t next_grant;
    sbarb_master_t next_last;
    sbarb_master_t req;
    sbarb_master_t high;
    sbarb_master_t winner;
    sbarb_master_t park;
    logic bus_idle;

    // rotate: the requester not served last goes first
    function automatic sbarb_master_t pick(input sbarb_master_t r, input sbarb_master_t prev);
        sbarb_master_t p;
        p = 2'h0;
        if (r == 2'h3) begin
            p = (prev == 2'h2) ? 2'h1 : 2'h2;
        end else begin
            p = r;
        end
        return p;
    endfunction

    assign bus_idle = FRAME_N & IRDY_N;
    assign req = {BRIDGE_REQ, ~REQ0_N & ~ign_ctl[`SBARB_IGN_PORT0]};
    assign high = {pri_ctl[`SBARB_PRI_BRIDGE_HIGH], pri_ctl[`SBARB_PRI_PORT0_HIGH]};
    assign park = pri_ctl[`SBARB_PRI_PARK_BRIDGE] ? 2'h2 : last;
    assign ex.run = (state == SBARB_ARB) && grant[0] && req[0] && bus_idle
        && ign_ctl[`SBARB_IGN_EXPIRY_EN];

    always_comb begin
        if ((req & high) != 2'h0) begin
            winner = pick(req & high, last);
        end else begin
            winner = pick(req & ~high, last);
        end
        next_state = state;
        next_grant = grant;
        next_last = last;
        case (state)
            SBARB_ARB: begin
                if (ex.expired) begin
                    // silent master loses its turn; no master is granted until re-arbitration after the hold cycle
                    next_grant = 2'h0;
                    next_last = 2'h1;
                    next_state = SBARB_HOLD;
                end else if (!FRAME_N) begin
                    next_last = (grant != 2'h0) ? grant : last;
                    next_state = SBARB_BUSY;
                end else if (bus_idle) begin
                    next_grant = (req != 2'h0) ? winner : park;
                end
            end
            SBARB_BUSY: begin
                if (bus_idle) begin
                    next_state = SBARB_ARB;
                end
            end
            SBARB_HOLD: begin
                // one dead cycle with no grant before re-arbitrating
                next_state = SBARB_ARB;
            end
            default: begin
                next_state = SBARB_ARB;
                next_grant = 2'h2;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (cfg_clear) begin
            state <= SBARB_ARB;
            grant <= 2'h2;
            last <= 2'h2;
            GNT0_N <= 1'b1;
            BRIDGE_GNT <= 1'b1;
        end else begin
            state <= next_state;
            grant <= next_grant;
            last <= next_last;
            GNT0_N <= ~next_grant[0];
            BRIDGE_GNT <= next_grant[1];
        end
    end

    // ------------------------------------------------------------
    // configuration bytes
    // ------------------------------------------------------------
    logic [7:0] next_vendor_a;
    logic [7:0] next_pri_ctl;
    logic [7:0] next_ign_ctl;
    logic next_flag;
    logic [7:0] next_rdata;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    always_comb begin
        next_vendor_a = vendor_a;
        next_pri_ctl = pri_ctl;
        next_ign_ctl = ign_ctl;
        next_flag = port0_expiry_flag;
        next_rdata = 8'h00;
        // reserved bits are stored as written; software is trusted to keep them zero
        if (CFG_WR && hit(CFG_ADDR, `SBARB_OFS_VENDOR_A)) begin
            next_vendor_a = CFG_WDATA;
        end
        if (CFG_WR && hit(CFG_ADDR, `SBARB_OFS_PRIORITY)) begin
            next_pri_ctl = CFG_WDATA;
        end
        if (CFG_WR && hit(CFG_ADDR, `SBARB_OFS_IGNORE)) begin
            next_ign_ctl = CFG_WDATA;
        end
        if (CFG_RD) begin
            case (CFG_ADDR)
                `SBARB_OFS_VENDOR_A: next_rdata = vendor_a;
                `SBARB_OFS_VENDOR_B: next_rdata = `SBARB_RST_VENDOR_B;
                `SBARB_OFS_PRIORITY: next_rdata = pri_ctl;
                `SBARB_OFS_IGNORE: next_rdata = ign_ctl;
                `SBARB_OFS_EXPIRY_STAT: next_rdata = {7'h00, port0_expiry_flag};
                default: next_rdata = 8'h00;
            endcase
            if (hit(CFG_ADDR, `SBARB_OFS_EXPIRY_STAT)) begin
                next_flag = 1'b0;
            end
        end
        // hardware set wins over a clear or write in the same cycle
        if (ex.expired) begin
            next_flag = 1'b1;
            if (ign_ctl[`SBARB_IGN_AUTO_MASK]) begin
                next_ign_ctl[`SBARB_IGN_PORT0] = 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (cfg_clear) begin
            vendor_a <= `SBARB_RST_VENDOR_A;
            pri_ctl <= `SBARB_RST_PRIORITY;
            ign_ctl <= `SBARB_RST_IGNORE;
            port0_expiry_flag <= 1'b0;
            CFG_RDATA <= 8'h00;
        end else begin
            vendor_a <= next_vendor_a;
            pri_ctl <= next_pri_ctl;
            ign_ctl <= next_ign_ctl;
            port0_expiry_flag <= next_flag;
            CFG_RDATA <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking dc @(posedge CLOCK); endclocking
    default disable iff (cfg_clear);

    a_grant_single: assert property ($onehot0(grant) && (grant == {BRIDGE_GNT, ~GNT0_N}))
        else $error("grant not single or outputs disagree");
    a_rotate_within: assert property (state == SBARB_ARB && bus_idle && !ex.expired
        && req == 2'h3 && high[0] == high[1] |=> grant != $past(last))
        else $error("same master served twice while other waited");
    a_park_bridge: assert property (state == SBARB_ARB && bus_idle && !ex.expired
        && req == 2'h0 && pri_ctl[7] |=> BRIDGE_GNT && GNT0_N)
        else $error("idle bus not parked on bridge");
    a_bridge_high: assert property (state == SBARB_ARB && bus_idle && !ex.expired
        && req == 2'h3 && pri_ctl[6] && !pri_ctl[0] |=> BRIDGE_GNT)
        else $error("high tier bridge lost to low tier port 0");
    a_port0_high: assert property (state == SBARB_ARB && bus_idle && !ex.expired
        && req == 2'h3 && !pri_ctl[6] && pri_ctl[0] |=> !GNT0_N)
        else $error("high tier port 0 lost to low tier bridge");
    a_expiry_disabled: assert property (!ign_ctl[7] |-> ##1 !ex.expired)
        else $error("expiry while disabled");
    a_expiry_drops: assert property (ex.expired && state == SBARB_ARB
        |=> GNT0_N && !BRIDGE_GNT ##1 state == SBARB_ARB)
        else $error("silent master kept its grant");
    a_auto_mask: assert property (ex.expired && ign_ctl[6] |=> ign_ctl[0] && !req[0])
        else $error("expired request not masked");
    a_ignore_port0: assert property ($rose(~GNT0_N)
        |-> (!$past(REQ0_N) && !$past(ign_ctl[0])) || !$past(pri_ctl[7]))
        else $error("ignored port 0 request was granted");
    a_count_restart: assert property (!ex.run |=> ex.count == 5'h00)
        else $error("expiry count kept running after the wait broke");
    a_flag_set: assert property (ex.expired |=> port0_expiry_flag)
        else $error("expiry flag not set");
    a_vendor_b_zero: assert property (CFG_RD && CFG_ADDR == 8'hda |=> CFG_RDATA == 8'h00)
        else $error("read-only vendor byte not zero");
    a_reset_values: assert property (disable iff (RST) $fell(cfg_clear)
        |-> pri_ctl == 8'h40 && ign_ctl == 8'h00 && vendor_a == 8'h00)
        else $error("control bytes not at reset values");

    c_busy_cycle: cover property (state == SBARB_ARB ##1 state == SBARB_BUSY ##[1:20] state == SBARB_ARB);
    c_expiry_mask: cover property (ex.expired && ign_ctl[6]);
    c_both_request: cover property (req == 2'h3 && bus_idle ##1 grant != $past(grant));
    c_flag_read: cover property (port0_expiry_flag && CFG_RD && CFG_ADDR == 8'hde);
endmodule

// ===== tb/sbarb_master_model.sv
// behavioural port 0 bus master that answers its grant with a short burst
`timescale 1ns/1ps
module sbarb_master_model (
    // clock
    input wire logic clk,
    // arbiter side
    input wire logic gnt_n,
    // bench control: lag below zero never starts a frame
    input wire logic want,
    input wire logic signed [31:0] lag,
    // bus side, driven high by this model when idle
    output logic req_n,
    output logic frame_n,
    output logic irdy_n
);
    int cnt;
    int beat;
    // one process owns every output, so no second driver appears
    initial begin
        req_n = 1'b1;
        frame_n = 1'b1;
        irdy_n = 1'b1;
        cnt = 0;
        beat = 0;
        forever begin
            @(posedge clk);
            #1;
            req_n = !want;
            if (beat > 0) begin
                beat = beat - 1;
                frame_n = (beat > 1) ? 1'b0 : 1'b1;
                irdy_n = (beat > 0) ? 1'b0 : 1'b1;
            end else if (want && !gnt_n && frame_n && irdy_n) begin
                // frame starts only on an idle bus with grant held
                if (lag >= 0 && cnt >= lag) begin
                    beat = 3;
                    frame_n = 1'b0;
                    irdy_n = 1'b0;
                    cnt = 0;
                end else begin
                    cnt = cnt + 1;
                end
            end else begin
                cnt = 0;
            end
        end
    end
endmodule

// ===== tb/secondary_bus_arbiter_bench.sv
// self-checking bench for the secondary bus arbiter
`timescale 1ns/1ps
module secondary_bus_arbiter_bench;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic link_n = 1'b1;
    logic glob_n = 1'b1;
    logic req0_n, frame_n, irdy_n, gnt0_n, bridge_gnt;
    logic bridge_req = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic cfg_wr = 1'b0;
    logic cfg_rd = 1'b0;
    logic [7:0] cfg_wdata = 8'h00;
    logic [7:0] cfg_rdata;
    logic want = 1'b0;
    int lag = 0;
    int errors = 0;
    int check_count = 0;

    always #25 clock = ~clock;

    sbarb_top #(.EXPIRY_CLKS(16)) i_sbarb_top (.CLOCK(clock), .RST(rst),
        .LINK_RESET_N(link_n), .GLOBAL_RESET_N(glob_n), .REQ0_N(req0_n),
        .FRAME_N(frame_n), .IRDY_N(irdy_n), .GNT0_N(gnt0_n), .BRIDGE_REQ(bridge_req),
        .BRIDGE_GNT(bridge_gnt), .CFG_ADDR(cfg_addr), .CFG_WR(cfg_wr), .CFG_RD(cfg_rd),
        .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata));
    sbarb_master_model i_sbarb_master_model (.clk(clock), .gnt_n(gnt0_n), .want(want),
        .lag(lag), .req_n(req0_n), .frame_n(frame_n), .irdy_n(irdy_n));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clock);
        #2;
    endtask
    task automatic cfg_write(logic [7:0] a, logic [7:0] d);
        cyc(1);
        cfg_addr = a;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        cyc(1);
        cfg_wr = 1'b0;
    endtask
    task automatic cfg_read(logic [7:0] a, logic [7:0] exp);
        cyc(1);
        cfg_addr = a;
        cfg_rd = 1'b1;
        cyc(1);
        cfg_rd = 1'b0;
        check($sformatf("cfg byte %h", a), cfg_rdata, exp);
    endtask
    // bounded waits; a miss shows as a mismatch on the final level
    task automatic until_gnt0(logic v);
        int n;
        n = 0;
        while (gnt0_n !== v && n < 40) begin
            cyc(1);
            n++;
        end
        check("port 0 grant", gnt0_n, v);
    endtask
    task automatic until_frame();
        int n;
        n = 0;
        while (frame_n !== 1'b0 && n < 40) begin
            cyc(1);
            n++;
        end
        check("frame start", frame_n, 1'b0);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        logic [7:0] ofs [6] = '{8'hd9, 8'hda, 8'hdc, 8'hdd, 8'hde, 8'hdb};
        logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            cfg_read(ofs[i], rv[i]);
        end
        cfg_write(8'hda, 8'hff);
        cfg_read(8'hda, 8'h00);
        cfg_write(8'hdc, 8'h81); // reserved bits left zero
        cfg_read(8'hdc, 8'h81);
        cfg_write(8'hdc, 8'h40);
        check("parked on bridge", bridge_gnt, 1'b1);
    endtask
    task automatic t_park();
        lag = 2;
        want = 1'b1;
        until_gnt0(1'b0);
        until_frame();
        want = 1'b0;
        cyc(8);
        check("park on last owner", gnt0_n, 1'b0);
        cfg_write(8'hdc, 8'hc0);
        cyc(3);
        check("park on bridge", bridge_gnt, 1'b1);
        check("port 0 released", gnt0_n, 1'b1);
    endtask
    task automatic t_tier();
        cfg_write(8'hdc, 8'h40);
        lag = 4;
        bridge_req = 1'b1;
        want = 1'b1;
        cyc(4);
        check("bridge high tier wins", bridge_gnt, 1'b1);
        check("port 0 low tier", gnt0_n, 1'b1);
        cfg_write(8'hdc, 8'h01);
        until_gnt0(1'b0);
        // port 0 must own the bus once before equal tiers can rotate away from it
        until_frame();
        cfg_write(8'hdc, 8'h41);
        cyc(6);
        check("rotation to bridge", bridge_gnt, 1'b1);
        want = 1'b0;
        bridge_req = 1'b0;
        cfg_write(8'hdc, 8'hc0);
    endtask
    task automatic t_ignore();
        cfg_write(8'hdd, 8'h01);
        lag = 0;
        want = 1'b1;
        cyc(20);
        check("ignored request", gnt0_n, 1'b1);
        cfg_write(8'hdd, 8'h00);
        until_gnt0(1'b0);
        until_frame();
        want = 1'b0;
        cyc(6);
    endtask
    task automatic t_expiry();
        int n;
        cfg_write(8'hdd, 8'hc0);
        lag = -1;
        want = 1'b1;
        until_gnt0(1'b0);
        n = 0;
        while (gnt0_n === 1'b0 && n < 40) begin
            cyc(1);
            n++;
        end
        check("expiry span", 8'(n >= 16 && n <= 18), 8'h01);
        cfg_read(8'hde, 8'h01);
        cfg_read(8'hde, 8'h00);
        cfg_read(8'hdd, 8'hc1);
        cyc(10);
        check("masked after expiry", gnt0_n, 1'b1);
        cfg_write(8'hdd, 8'h80);
        until_gnt0(1'b0);
        cyc(25);
        cfg_read(8'hdd, 8'h80);
        cfg_read(8'hde, 8'h01);
        cfg_write(8'hdd, 8'h00);
        until_gnt0(1'b0);
        cyc(40);
        check("no expiry when off", gnt0_n, 1'b0);
        cfg_read(8'hde, 8'h00);
        want = 1'b0;
        lag = 1;
        cyc(4);
    endtask
    task automatic t_freset();
        cfg_write(8'hdc, 8'h81);
        cfg_write(8'hdd, 8'h41);
        glob_n = 1'b0;
        cyc(5);
        glob_n = 1'b1;
        cyc(6);
        cfg_read(8'hdc, 8'h40);
        cfg_write(8'hdd, 8'h41);
        link_n = 1'b0;
        cyc(5);
        link_n = 1'b1;
        cyc(6);
        cfg_read(8'hdd, 8'h00);
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        // about 4000 clocks, several times the whole run even if every wait runs out
        #200000;
        errors++;
        close_out();
    end
    initial begin
        cyc(6);
        rst = 1'b0;
        cyc(6);
        t_regs();
        t_park();
        t_tier();
        t_ignore();
        t_expiry();
        t_freset();
        close_out();
    end
endmodule
